// >>> core_model.sv
/* core model: takes the shown vector 2 or 7 cycles after irq; one clock */
`timescale 1ns/1ns
module core_model (
  input wire clk, reset, slow, core_irq,
  input wire [7:0] core_vector,
  output reg core_take,
  output reg [7:0] taken_vector
);
  reg [3:0] wait_reg;
  always @(posedge clk) begin
    core_take <= 1'b0;
    if (reset || core_take || !core_irq) wait_reg <= 4'h0;
    else wait_reg <= wait_reg + 4'h1;
    if (reset) taken_vector <= 8'h00;
    else if (core_take) taken_vector <= core_vector;
    else if (core_irq && wait_reg == (slow ? 4'h6 : 4'h1)) core_take <= 1'b1;
  end
endmodule // core_model

// >>> irq_ctrl.v
/*
 * posted interrupt clear/set unit with ahb-lite register slave, masks,
 * global enable, vector clear and priority vector to the core.
 * assumes one clock, synchronous reset, sources as one-cycle or level posts.
 */
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "irq_ctrl_defines.vh"
module irq_ctrl #(
  parameter N = `NUM_SRC
) (
  input wire clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [N-1:0] src_post,
  input wire core_take,
  output wire core_irq,
  output wire [7:0] core_vector,
  output wire irq
);
  // source order in the flag vector: bit i has vector 4*(i+1)
  // 0 monitor,1 analog,2 touch,3 timer_zero_irq,4 pin,5 spi,6 i2c,7 sleep,8 timer_one_irq,9 timer_two_irq
  reg [N-1:0] posted_reg;
  reg [N-1:0] posted_next;
  reg [N-1:0] mask_reg;
  reg soft_post_enable_reg;
  reg global_irq_enable_reg;
  reg [`NUM_EV-1:0] stat_reg;
  reg [`NUM_EV-1:0] stat_next;
  reg [`NUM_EV-1:0] imask_reg;
  reg wr_pend_reg;
  reg [7:0] wr_idx_reg;
  reg [N-1:0] soft_set;
  reg [N-1:0] soft_clr;
  reg vc_clear;
  wire [N-1:0] pending;
  wire [N-1:0] take_onehot;
  wire [7:0] top_vector;
  wire addr_phase;
  wire [7:0] a_idx;
  wire [N-1:0] taken;
  wire [N-1:0] msk0_flags;

  // map a clear register image onto the flag vector
  function [N-1:0] to_flags;
    input [7:0] idx;
    input [7:0] data;
    begin
      to_flags = {N{1'b0}};
      if (idx == `IDX_CLR0)
        to_flags[7:0] = {data[6], data[7], data[5], data[4], data[3], data[2], data[1],
          data[0]};
      else if (idx == `IDX_CLR1)
        to_flags[9:8] = data[`CLR1_BITS-1:0];
    end
  endfunction

  // flag vector back into a register image
  function [7:0] to_image;
    input [7:0] idx;
    input [N-1:0] f;
    begin
      to_image = `RST_BYTE;
      if (idx == `IDX_CLR0)
        to_image = {f[6], f[7], f[5], f[4], f[3], f[2], f[1], f[0]};
      else if (idx == `IDX_CLR1)
        to_image = {6'h00, f[9:8]};
    end
  endfunction

  // flags a clear register write touches
  function [N-1:0] reg_bits;
    input [7:0] idx;
    begin
      reg_bits = to_flags(idx, 8'hff);
    end
  endfunction

  assign addr_phase = hsel && hready && htrans[1];
  assign a_idx = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign pending = posted_reg & mask_reg;
  // first mask register shares the first clear register's bit layout
  assign msk0_flags = to_flags(`IDX_CLR0, hwdata[7:0]);

  prio_encoder #(
    .N(N)
  ) u_prio (
    .pending(pending),
    .vector(top_vector),
    .onehot(take_onehot)
  );

  assign core_irq = global_irq_enable_reg && (|pending);
  assign core_vector = top_vector;
  assign taken = (core_take && core_irq) ? take_onehot : {N{1'b0}};
  assign irq = |(stat_reg & imask_reg);

  // decode of the data phase write
  always @* begin
    soft_set = {N{1'b0}};
    soft_clr = {N{1'b0}};
    vc_clear = 1'b0;
    if (wr_pend_reg) begin
      if (wr_idx_reg == `IDX_VC)
        vc_clear = 1'b1;
      else if (soft_post_enable_reg)
        soft_set = to_flags(wr_idx_reg, hwdata[7:0]);
      else
        soft_clr = reg_bits(wr_idx_reg) & ~to_flags(wr_idx_reg, hwdata[7:0]);
    end
  end

  // flags hold until taken or cleared; hardware post wins over clear
  always @* begin
    posted_next = posted_reg & ~soft_clr & ~taken;
    if (vc_clear)
      posted_next = {N{1'b0}};
    posted_next = posted_next | soft_set | src_post;
  end

  always @* begin
    stat_next = stat_reg;
    if (wr_pend_reg && wr_idx_reg == `IDX_STAT)
      stat_next = stat_reg & ~hwdata[`NUM_EV-1:0];
    if (|src_post)
      stat_next[`EV_POST] = 1'b1;
    if (|soft_set)
      stat_next[`EV_SOFT] = 1'b1;
    if (vc_clear || (|(soft_clr & posted_reg)))
      stat_next[`EV_CLEAR] = 1'b1;
  end

  always @(posedge clk) begin
    if (reset) begin
      posted_reg <= `RST_SRC;
      mask_reg <= `RST_SRC;
      soft_post_enable_reg <= `RST_BIT;
      global_irq_enable_reg <= `RST_BIT;
      stat_reg <= {`NUM_EV{1'b0}};
      imask_reg <= {`NUM_EV{1'b0}};
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= `RST_BYTE;
    end else begin
      posted_reg <= posted_next;
      stat_reg <= stat_next;
      wr_pend_reg <= addr_phase && hwrite;
      wr_idx_reg <= a_idx;
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `IDX_MSK0: mask_reg[7:0] <= msk0_flags[7:0];
          `IDX_MSK1: mask_reg[9:8] <= hwdata[`CLR1_BITS-1:0];
          `IDX_SWEN: soft_post_enable_reg <= hwdata[0];
          `IDX_GIE: global_irq_enable_reg <= hwdata[0];
          `IDX_IMSK: imask_reg <= hwdata[`NUM_EV-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data captured at the address phase, valid in the data phase
  always @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      case (a_idx)
        `IDX_CLR0, `IDX_CLR1: hrdata <= {24'h000000, to_image(a_idx, posted_next)};
        `IDX_CLR2: hrdata <= 32'h00000000;
        `IDX_MSK0: hrdata <= {24'h000000, to_image(`IDX_CLR0, mask_reg)};
        `IDX_MSK1: hrdata <= {24'h000000, to_image(`IDX_CLR1, mask_reg)};
        `IDX_SWEN: hrdata <= {31'h00000000, soft_post_enable_reg};
        `IDX_VC: hrdata <= {24'h000000, top_vector};
        `IDX_GIE: hrdata <= {31'h00000000, global_irq_enable_reg};
        `IDX_STAT: hrdata <= {29'h00000000, stat_next};
        `IDX_IMSK: hrdata <= {29'h00000000, imask_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // irq_ctrl

// >>> irq_ctrl_defines.vh
/*
 * register offsets, field positions, reset values and vectors of the posted
 * interrupt clear/set unit. assumes it is included by bare name.
 */
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

`define NUM_SRC 10
// printed offsets are not word aligned: indexes, byte address is four times
`define IDX_CLR0 8'hda
`define IDX_CLR1 8'hdb
`define IDX_CLR2 8'hdc
`define IDX_MSK1 8'hdf
`define IDX_MSK0 8'he0
`define IDX_SWEN 8'he1
`define IDX_VC 8'he2
`define IDX_GIE 8'he3
`define IDX_TAKE 8'he4
`define IDX_STAT 8'he5
`define IDX_IMSK 8'he6

`define RST_BYTE 8'h00
`define RST_SRC 10'h000
`define RST_BIT 1'b0
`define CLR1_BITS 2
`define ZERO_VECTOR 8'h00
`define FIRST_VECTOR 8'h04
`define VECTOR_STEP 8'h04

// status events of the block's own interrupt output
`define EV_POST 0
`define EV_SOFT 1
`define EV_CLEAR 2
`define NUM_EV 3
`endif

// >>> irq_ctrl_properties.sv
/* port assertions of irq_ctrl; bound into every irq_ctrl below */
`timescale 1ns/1ns
module irq_ctrl_checker #(parameter N = 10) (
  input wire clk, reset, hsel, hwrite, hreadyout, hresp, core_take, core_irq,
  input wire [1:0] htrans,
  input wire [31:0] hrdata,
  input wire [N-1:0] src_post,
  input wire [7:0] core_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus stall");
  chk_vector_table: assert property (core_irq |-> core_vector inside {[8'h04:8'h28]})
    else $error("vector off table");
  chk_vector_step: assert property (core_vector[1:0] == 2'b00)
    else $error("vector misaligned");
  chk_idle_vector: assert property (core_vector == 8'h00 |-> !core_irq)
    else $error("irq with no vector");
  chk_flags_hold: assert property ((!hsel && !core_take && src_post == '0)[*2] |=>
    $stable(core_vector) && $stable(core_irq)) else $error("flags moved");
  chk_take_moves: assert property (core_take && core_irq && src_post == '0 && !hsel &&
    !$past(hsel) |=> core_vector != $past(core_vector)) else $error("take ignored");
  chk_read_holds: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  chk_reset_idle: assert property ($fell(reset) |-> !core_irq && core_vector == 8'h00)
    else $error("busy after reset");
endmodule // irq_ctrl_checker
bind irq_ctrl irq_ctrl_checker #(.N(N)) chk_u (.clk(clk), .reset(reset), .hsel(hsel),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .core_take(core_take),
  .core_irq(core_irq), .htrans(htrans), .hrdata(hrdata), .src_post(src_post),
  .core_vector(core_vector));

// >>> irq_ctrl_tb_top.sv
/* irq_ctrl bench: ahb-lite register tasks; assumes core_model and the index macros */
`timescale 1ns/1ns
`include "irq_ctrl_defines.vh"
module irq_ctrl_tb_top;
  reg clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [9:0] src_post = 10'h000;
  reg [16:0] op;
  wire hreadyout, hresp, core_take, core_irq, irq;
  wire [31:0] hrdata;
  wire [7:0] core_vector, taken_vector;
  integer fails = 0, comparisons = 0, n, k;
  // write flag, index, data (expected data for reads)
  localparam [17*16-1:0] OPS = {17'h0daff, 17'h0db03, 17'h1dafe, 17'h1dafe, 17'h1db01,
    17'h0dafe, 17'h0db01, 17'h1e101, 17'h1da00, 17'h1db02, 17'h0dafe, 17'h0db03,
    17'h1da01, 17'h0daff, 17'h1e100, 17'h1e200};
  irq_ctrl dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src_post(src_post), .core_take(core_take),
    .core_irq(core_irq), .core_vector(core_vector), .irq(irq));
  core_model core_u (.clk(clk), .reset(reset), .slow(slow), .core_irq(core_irq),
    .core_vector(core_vector), .core_take(core_take), .taken_vector(taken_vector));
  initial forever #20 clk = ~clk;
  task print_verdict;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task ck(input string s, input [7:0] e, g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        $display("BAD %s expected %h seen %h", s, e, g);
        fails = fails + 1;
      end
    end
  endtask
  task tick;
    begin
      n = n + 1;
      if (n > 50) begin
        fails = fails + 1;
        print_verdict;
      end
      @(posedge clk);
    end
  endtask
  task bus(input w, input [7:0] i, d);
    begin
      {hsel, htrans, hwrite, haddr} <= {3'b110, w, 22'h0, i, 2'b00};
      n = 0;
      tick;
      while (hreadyout !== 1'b1) tick;
      {hsel, htrans, hwdata} <= {3'b000, 24'h0, d};
      tick;
      while (hreadyout !== 1'b1) tick;
      if (!w) ck($sformatf("index %h", i), d, hrdata[7:0]);
    end
  endtask
  task post(input [9:0] p);
    begin
      src_post <= p;
      @(posedge clk);
      src_post <= 10'h000;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(0, `IDX_SWEN, 8'h00);
    bus(0, 8'hf0, 8'h00);
    post(10'h3ff);
    for (k = 0; k < 16; k = k + 1) begin
      op = OPS[(15 - k) * 17 +: 17];
      bus(op[16], op[15:8], op[7:0]);
    end
    bus(0, `IDX_CLR0, 8'h00);
    $display("clear and soft post test done");
    bus(1, `IDX_MSK1, 8'h03);
    post(10'h050);
    bus(0, `IDX_CLR0, 8'h90);
    ck("vector", 8'h00, core_vector);
    bus(1, `IDX_MSK0, 8'hff);
    #1 ck("vector", 8'h14, core_vector);
    ck("core irq", 8'h00, core_irq);
    slow <= 1'b1;
    bus(1, `IDX_GIE, 8'h01);
    #1 n = 0;
    while (core_irq !== 1'b0) tick;
    bus(0, `IDX_CLR0, 8'h00);
    ck("taken", 8'h1c, taken_vector);
    bus(1, `IDX_GIE, 8'h00);
    for (k = 0; k < 10; k = k + 1) begin
      post(10'h3ff << k);
      #1 ck("vector", 8'h04 * (k + 1), core_vector);
      bus(1, `IDX_VC, 8'h00);
    end
    $display("priority test done");
    src_post <= 10'h008;
    bus(1, `IDX_CLR0, 8'h00);
    src_post <= 10'h000;
    bus(0, `IDX_CLR0, 8'h08);
    bus(0, `IDX_STAT, 8'h07);
    ck("irq", 8'h00, irq);
    bus(1, `IDX_IMSK, 8'h02);
    #1 ck("irq", 8'h01, irq);
    bus(1, `IDX_STAT, 8'h07);
    bus(0, `IDX_STAT, 8'h00);
    ck("irq", 8'h00, irq);
    $display("status test done");
    print_verdict;
  end
endmodule // irq_ctrl_tb_top

// >>> prio_encoder.v
/*
 * fixed priority encoder: lowest pending index wins and is turned into the
 * vector the core fetches. assumes pending vector is already masked.
 */
`timescale 1ns/1ns
`include "irq_ctrl_defines.vh"
module prio_encoder #(
  parameter N = `NUM_SRC
) (
  input wire [N-1:0] pending,
  output reg [7:0] vector,
  output reg [N-1:0] onehot
);
  integer i;
  reg found;
  always @* begin
    vector = `ZERO_VECTOR;
    onehot = {N{1'b0}};
    found = 1'b0;
    // lowest index is highest priority
    for (i = 0; i < N; i = i + 1) begin
      if (pending[i] && !found) begin
        found = 1'b1;
        onehot[i] = 1'b1;
        vector = `FIRST_VECTOR + i[7:0] * `VECTOR_STEP;
      end
    end
  end
endmodule // prio_encoder
